// ### tb.sv
// Self-checking bench for the boot entry block.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ube_pkg::*;
	logic           aclk, aresetn, rx, tx, pin, wdg, boot, got;
	ube_axil_req_t  req;
	ube_axil_resp_t resp;
	logic [7:0]     gb, aq[$], fb[18];
	logic [33:0]    eq[$], mq[$], m;
	int             errors = 0, n_compared = 0;
	logic [17:0]    ra[6] = '{CTRL_ADDR, BAUD_ADDR, FCR2_ADDR,
		NFCR2_ADDR, OPT_ADDR, NOPT_ADDR};
	logic [31:0]    rv[6] = '{32'h0, 32'h364, 32'h0, 32'hFF, 32'h0, 32'h0};
	logic [7:0]     cmds[5] = '{CMD_GET, CMD_READ, CMD_GO, CMD_WRITE,
		CMD_ERASE};
	ube_boot_entry u_ube_boot_entry (.aclk(aclk), .aresetn(aresetn),
		.axil_req(req), .axil_resp(resp), .uart_rx_in(rx),
		.uart_tx_out(tx), .boot_force_irq_in(pin),
		.watchdog_forced_reset(wdg), .boot_mode_out(boot));
	ube_prog_model #(.BIT(10)) u_ube_prog_model (.aclk(aclk),
		.line_in(tx), .line_out(rx), .force_out(pin), .got(got),
		.got_byte(gb));
	always #5 aclk = ~aclk;
	task automatic chk(input string s, input logic [33:0] seen, e);
		n_compared++;
		if (seen !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", s, e, seen);
		end
	endtask
	task automatic test_done;
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Ready lines stay high, so each answer lasts one cycle.
	task automatic wr(input logic [17:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic aw_go, w_go;
		aw_go = 1'b1;
		w_go = 1'b1;
		eq.push_back({r, 32'h0});
		mq.push_back({2'b11, 32'h0});
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		// Offers are tracked locally; req itself updates after the edge.
		while (aw_go || w_go) begin
			@(posedge aclk);
			if (aw_go && resp.awready) begin
				aw_go = 1'b0;
				req.awvalid <= 1'b0;
			end
			if (w_go && resp.wready) begin
				w_go = 1'b0;
				req.wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!resp.bvalid);
	endtask
	task automatic rd(input logic [17:0] a, input logic [33:0] e, k);
		eq.push_back(e);
		mq.push_back(k);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		do @(posedge aclk); while (!resp.arready);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (!resp.rvalid);
	endtask
	// Pairs each bus answer and each heard frame with the oldest note.
	always @(posedge aclk) begin
		if (resp.bvalid || resp.rvalid) begin
			m = mq.pop_front();
			chk("axi", m & (resp.bvalid ? {resp.bresp, 32'h0}
				: {resp.rresp, resp.rdata}), m & eq.pop_front());
		end
		if (got)
			chk("uart", {26'h0, gb}, {26'h0, aq.pop_front()});
	end
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		void'($urandom(32'hEE6030DC));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		foreach (ra[i]) rd(ra[i], {2'b00, rv[i]}, '1);
		rd(18'h00028, {RESP_SLVERR, 32'h0}, '1);
		wr(18'h00028, 32'h0, RESP_SLVERR);
		// A locked option byte must refuse the write quietly.
		wr(OPT_ADDR, 32'h55, RESP_OKAY);
		rd(OPT_ADDR, 34'h0, '1);
		wr(BAUD_ADDR, 32'h9, RESP_OKAY);
		wr(CTRL_ADDR, 32'h3, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("boot", {33'h0, boot}, 34'h0);
		u_ube_prog_model.pulse(4);
		for (int i = 0; i < 30 && !wdg; i++) @(posedge aclk);
		chk("force", {33'h0, wdg}, 34'h1);
		@(posedge aclk);
		chk("boot", {33'h0, boot}, 34'h1);
		rd(OPT_ADDR, {2'b00, 24'h0, OPT_BOOT}, '1);
		rd(NOPT_ADDR, {2'b00, 24'h0, NOPT_BOOT}, '1);
		aq.push_back(ACK_BYTE);
		u_ube_prog_model.send(SYNC_BYTE, 1'b0);
		wr(CMD_ADDR, 32'h0, RESP_OKAY);
		aq.push_back(NACK_BYTE);
		u_ube_prog_model.send(8'h55, 1'b0);
		foreach (cmds[i]) begin
			wr(CMD_ADDR, 32'h0, RESP_OKAY);
			aq.push_back(ACK_BYTE);
			u_ube_prog_model.send(cmds[i], 1'b0);
		end
		// Sixteen stored, one pending, the last one overruns.
		for (int i = 0; i < 18; i++) begin
			fb[i] = 8'($urandom());
			u_ube_prog_model.send(fb[i], 1'b0);
		end
		rd(STATUS_ADDR, {2'b00, 32'h10}, {2'b11, 32'h10});
		for (int i = 0; i < 17; i++)
			rd(RXDATA_ADDR, {2'b00, 23'h0, 1'b1, fb[i]}, {2'b11, 32'h1FF});
		rd(RXDATA_ADDR, 34'h0, {2'b11, 32'h100});
		u_ube_prog_model.send(8'h5A, 1'b1);
		rd(STATUS_ADDR, {2'b00, 32'h8}, {2'b11, 32'h8});
		// Clearing the line_err and overrun flags must leave them low.
		wr(STATUS_ADDR, 32'h18, RESP_OKAY);
		rd(STATUS_ADDR, 34'h0, {2'b11, 32'h18});
		// A software byte goes out on the link once the line is free.
		aq.push_back(8'hA5);
		wr(TXDATA_ADDR, 32'hA5, RESP_OKAY);
		for (int i = 0; i < 500 && aq.size() != 0; i++) @(posedge aclk);
		chk("acks left", 34'(aq.size()), 34'h0);
		test_done();
	end
	// Cuts a hang short well past the expected run length.
	initial begin
		#300us;
		errors++;
		test_done();
	end
endmodule

// ### ube_boot_entry.sv
// Target-side boot entry handler, bootloader UART and AXI4-Lite registers.
//
// The AXI4-Lite register port was decided locally.
module ube_boot_entry (
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire ube_pkg::ube_axil_req_t axil_req,
	output ube_pkg::ube_axil_resp_t     axil_resp,
	input  wire logic            uart_rx_in,
	output logic                 uart_tx_out,
	input  wire logic            boot_force_irq_in,
	output logic                 watchdog_forced_reset,
	output logic                 boot_mode_out
);
	import ube_pkg::*;

	// ----------------------------------------------------------------
	// All state of the block except the FIFO's entries, pointers and level in one record.
	// ----------------------------------------------------------------
	typedef struct packed {
		ube_axil_resp_t axi;        // Registered bus answers.
		logic         aw_have;      // Write address held.
		logic [17:0]  awaddr;
		logic         w_have;       // Write data held.
		logic [31:0]  wdata;
		logic [3:0]   wstrb;
		logic [2:0]   irq_sync;     // Two sync stages plus edge history.
		logic [1:0]   rx_sync;      // Two sync stages for the RX pin.
		logic         handler_en;   // Interrupt pin enabled.
		logic         programmed;   // Flash holds an image.
		logic [15:0]  baud_div;     // Bit period in clocks, minus one.
		logic         unlock_arm;   // First unlock key seen.
		logic         unlocked;     // Data memory writable.
		logic [7:0]   cr2;
		logic [7:0]   flash_control_two_complement;
		logic [7:0]   opt;
		logic [7:0]   nopt;
		logic         opt_boot;     // Option pair latched at last forced reset.
		logic         wdg_arm;      // First watchdog key seen.
		logic         wdg_rst;      // Forced reset pulse.
		logic         boot_mode;
		ube_hstate_t  hst;
		ube_rxstate_t rst;
		logic [15:0]  rx_cnt;
		logic [2:0]   rx_bit;
		logic [7:0]   rx_sh;
		logic         rx_par;
		logic         pend;         // Payload byte waiting for the FIFO.
		logic [7:0]   pend_data;
		logic         synced;
		logic         sync_fail;
		logic         line_err;
		logic         overrun;
		logic         cmd_wait;     // Next byte is a command code.
		logic [7:0]   cmd;
		logic         cmd_known;
		logic         cmd_bad;
		logic         tx_busy;
		logic [15:0]  tx_cnt;
		logic [10:0]  tx_sh;
		logic [3:0]   tx_left;
		logic         tx_line;
		logic         ack_req;      // Hardware answer pending.
		logic [7:0]   ack_byte;
		logic         txq;          // Software byte pending.
		logic [7:0]   txq_data;
	} ube_st_t;

	ube_st_t     st;
	ube_st_t     next_st;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [7:0]  fifo_out_data;
	logic        fifo_pop;

	// Recognised bootloader command codes.
	function automatic logic is_cmd(input logic [7:0] b);
		return b == CMD_GET || b == CMD_READ || b == CMD_GO ||
		       b == CMD_WRITE || b == CMD_ERASE;
	endfunction

	// Whether an address names a register.
	function automatic logic addr_ok(input logic [17:0] a);
		return a == CTRL_ADDR || a == BAUD_ADDR || a == STATUS_ADDR ||
		       a == RXDATA_ADDR || a == TXDATA_ADDR || a == CMD_ADDR ||
		       a == UNLOCK_ADDR || a == FCR2_ADDR || a == NFCR2_ADDR ||
		       a == WDG_KEY_ADDR || a == OPT_ADDR || a == NOPT_ADDR;
	endfunction

	// ----------------------------------------------------------------
	// Received payload buffer.
	// ----------------------------------------------------------------
	ube_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (st.pend),
		.in_ready  (fifo_in_ready),
		.in_data   (st.pend_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// A read of the data register pops at the address handshake.
	assign fifo_pop = axil_req.arvalid && st.axi.arready &&
	                  axil_req.araddr == RXDATA_ADDR;

	assign axil_resp             = st.axi;
	assign uart_tx_out           = st.tx_line;
	assign watchdog_forced_reset = st.wdg_rst;
	assign boot_mode_out         = st.boot_mode;

	// ----------------------------------------------------------------
	// Next-state logic for bus, handler, receiver and transmitter.
	// ----------------------------------------------------------------
	always_comb begin
		logic        wr_en;
		logic [17:0] wr_addr;
		logic [31:0] wr_data;
		logic [31:0] m;
		logic        line;
		logic        got;
		logic [7:0]  b;
		logic [7:0]  d;
		wr_en   = 1'b0;
		wr_addr = '0;
		wr_data = '0;
		m       = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}},
		           {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
		got     = 1'b0;
		b       = '0;
		d       = '0;
		next_st = st;
		next_st.wdg_rst  = 1'b0;
		// Pins enter through two flops before any logic reads them.
		next_st.irq_sync = {st.irq_sync[1:0], boot_force_irq_in};
		next_st.rx_sync  = {st.rx_sync[0], uart_rx_in};
		line = st.rx_sync[1];

		// Bus handshakes: address and data are taken in either order.
		if (axil_req.awvalid && st.axi.awready) begin
			next_st.aw_have = 1'b1;
			next_st.awaddr  = axil_req.awaddr;
		end
		if (axil_req.wvalid && st.axi.wready) begin
			next_st.w_have = 1'b1;
			next_st.wdata  = axil_req.wdata;
			next_st.wstrb  = axil_req.wstrb;
		end
		if (st.axi.bvalid && axil_req.bready) begin
			next_st.axi.bvalid = 1'b0;
		end
		// Bus writes wait while the handler owns the register port.
		if (st.aw_have && st.w_have && !st.axi.bvalid && st.hst == H_IDLE) begin
			wr_en   = 1'b1;
			wr_addr = st.awaddr;
			wr_data = st.wdata;
			next_st.aw_have    = 1'b0;
			next_st.w_have     = 1'b0;
			next_st.axi.bvalid = 1'b1;
			next_st.axi.bresp  = addr_ok(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
		end else begin
			m = '1;
		end

		// Handler: a rising edge of the pin while enabled runs the sequence.
		unique case (st.hst)
			H_IDLE: begin
				if (st.irq_sync[1] && !st.irq_sync[2] && st.handler_en) begin
					next_st.hst = H_UNLOCK_A;
				end
			end
			H_UNLOCK_A: begin
				{wr_en, wr_addr, wr_data} = {1'b1, UNLOCK_ADDR, 24'h0, UNLOCK_KEY1};
				next_st.hst = H_UNLOCK_B;
			end
			H_UNLOCK_B: begin
				{wr_en, wr_addr, wr_data} = {1'b1, UNLOCK_ADDR, 24'h0, UNLOCK_KEY2};
				next_st.hst = H_CR2;
			end
			H_CR2: begin
				{wr_en, wr_addr, wr_data} = {1'b1, FCR2_ADDR, 24'h0, st.cr2 | OPT_WR_SET};
				next_st.hst = H_FLASH_CONTROL_TWO_COMPLEMENT;
			end
			H_FLASH_CONTROL_TWO_COMPLEMENT: begin
				{wr_en, wr_addr, wr_data} = {1'b1, NFCR2_ADDR, 24'h0, st.flash_control_two_complement & OPT_WR_CLR};
				next_st.hst = H_OPT;
			end
			H_OPT: begin
				{wr_en, wr_addr, wr_data} = {1'b1, OPT_ADDR, 24'h0, OPT_BOOT};
				next_st.hst = H_NOPT;
			end
			H_NOPT: begin
				{wr_en, wr_addr, wr_data} = {1'b1, NOPT_ADDR, 24'h0, NOPT_BOOT};
				next_st.hst = H_KEY_A;
			end
			H_KEY_A: begin
				{wr_en, wr_addr, wr_data} = {1'b1, WDG_KEY_ADDR, 24'h0, WDG_KEY1};
				next_st.hst = H_KEY_B;
			end
			H_KEY_B: begin
				{wr_en, wr_addr, wr_data} = {1'b1, WDG_KEY_ADDR, 24'h0, WDG_KEY2};
				next_st.hst = H_IDLE;
			end
			default: begin
				next_st.hst = H_IDLE;
			end
		endcase

		// Register writes; key registers only act on the right sequence.
		d = wr_data[7:0];
		if (wr_en && m[0]) begin
			unique case (wr_addr)
				CTRL_ADDR: begin
					next_st.handler_en = d[0];
					next_st.programmed = d[1];
				end
				STATUS_ADDR: begin
					// Write one to clear; hardware sets below still win.
					next_st.sync_fail = st.sync_fail & ~d[2];
					next_st.line_err  = st.line_err & ~d[3];
					next_st.overrun   = st.overrun & ~d[4];
				end
				TXDATA_ADDR: begin
					if (!st.txq) begin
						next_st.txq      = 1'b1;
						next_st.txq_data = d;
					end
				end
				CMD_ADDR: begin
					// Rearms command capture once the link has been synced.
					next_st.cmd_wait  = st.synced;
					next_st.cmd_known = 1'b0;
					next_st.cmd_bad   = 1'b0;
				end
				UNLOCK_ADDR: begin
					if (st.unlock_arm && d == UNLOCK_KEY2) begin
						next_st.unlocked = 1'b1;
					end
					next_st.unlock_arm = (d == UNLOCK_KEY1);
				end
				FCR2_ADDR:  next_st.cr2  = d;
				NFCR2_ADDR: next_st.flash_control_two_complement = d;
				WDG_KEY_ADDR: begin
					if (st.wdg_arm && d == WDG_KEY2) begin
						next_st.wdg_rst = 1'b1;
					end
					next_st.wdg_arm = (d == WDG_KEY1);
				end
				OPT_ADDR, NOPT_ADDR: begin
					// Options change only when unlocked and enabled.
					if (st.unlocked && st.cr2[7] && !st.flash_control_two_complement[7]) begin
						if (wr_addr == OPT_ADDR) begin
							next_st.opt = d;
						end else begin
							next_st.nopt = d;
						end
					end
				end
				default: begin
				end
			endcase
		end
		if (wr_en && wr_addr == BAUD_ADDR) begin
			next_st.baud_div = (st.baud_div & ~m[15:0]) | (wr_data[15:0] & m[15:0]);
		end

		// Bus reads; the status word shows the block's own state.
		if (st.axi.rvalid && axil_req.rready) begin
			next_st.axi.rvalid = 1'b0;
		end
		if (axil_req.arvalid && st.axi.arready) begin
			next_st.axi.rvalid = 1'b1;
			next_st.axi.rresp  = addr_ok(axil_req.araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (axil_req.araddr)
				CTRL_ADDR:    next_st.axi.rdata = {30'h0, st.programmed, st.handler_en};
				BAUD_ADDR:    next_st.axi.rdata = {16'h0, st.baud_div};
				STATUS_ADDR:  next_st.axi.rdata = {20'h0, fifo_out_valid, st.txq,
				                  st.tx_busy, st.unlocked, st.hst != H_IDLE,
				                  st.cmd_bad, st.cmd_known, st.overrun, st.line_err,
				                  st.sync_fail, st.synced, st.boot_mode};
				RXDATA_ADDR:  next_st.axi.rdata = {23'h0, fifo_out_valid, fifo_out_data};
				TXDATA_ADDR:  next_st.axi.rdata = {24'h0, st.txq_data};
				CMD_ADDR:     next_st.axi.rdata = {23'h0, st.cmd_wait, st.cmd};
				FCR2_ADDR:    next_st.axi.rdata = {24'h0, st.cr2};
				NFCR2_ADDR:   next_st.axi.rdata = {24'h0, st.flash_control_two_complement};
				OPT_ADDR:     next_st.axi.rdata = {24'h0, st.opt};
				NOPT_ADDR:    next_st.axi.rdata = {24'h0, st.nopt};
				default:      next_st.axi.rdata = '0;
			endcase
		end

		// Receiver: sample mid-bit; start, 8 data, even parity, stop.
		unique case (st.rst)
			RX_IDLE: begin
				if (!line) begin
					next_st.rst    = RX_START;
					next_st.rx_cnt = st.baud_div >> 1;
				end
			end
			RX_START, RX_DATA, RX_PAR, RX_STOP: begin
				next_st.rx_cnt = st.rx_cnt - 16'h0001;
				if (st.rx_cnt == 16'h0000) begin
					next_st.rx_cnt = st.baud_div;
					if (st.rst == RX_START) begin
						next_st.rst    = line ? RX_IDLE : RX_DATA;
						next_st.rx_bit = '0;
						next_st.rx_par = 1'b0;
					end else if (st.rst == RX_DATA) begin
						next_st.rx_sh  = {line, st.rx_sh[7:1]};
						next_st.rx_par = st.rx_par ^ line;
						next_st.rx_bit = st.rx_bit + 3'h1;
						if (st.rx_bit == 3'h7) begin
							next_st.rst = RX_PAR;
						end
					end else if (st.rst == RX_PAR) begin
						next_st.rx_par = st.rx_par ^ line;
						next_st.rst    = RX_STOP;
					end else begin
						next_st.rst = RX_IDLE;
						if (line && !st.rx_par) begin
							got = 1'b1;
						end else begin
							next_st.line_err = 1'b1;
						end
					end
				end
			end
			default: begin
				next_st.rst = RX_IDLE;
			end
		endcase

		// Session: sync first, then a command, then payload to the FIFO.
		b = st.rx_sh;
		if (st.pend && fifo_in_ready) begin
			next_st.pend = 1'b0;
		end
		if (got && st.boot_mode) begin
			if (!st.synced) begin
				if (b == SYNC_BYTE) begin
					next_st.synced   = 1'b1;
					next_st.cmd_wait = 1'b1;
					next_st.ack_req  = 1'b1;
					next_st.ack_byte = ACK_BYTE;
				end else begin
					// A wrong first byte sets sync_fail; commands are not captured until it is cleared.
					next_st.sync_fail = 1'b1;
				end
			end else if (st.cmd_wait && !st.sync_fail) begin
				next_st.cmd       = b;
				next_st.cmd_wait  = 1'b0;
				next_st.cmd_known = is_cmd(b);
				next_st.cmd_bad   = !is_cmd(b);
				next_st.ack_req   = 1'b1;
				next_st.ack_byte  = is_cmd(b) ? ACK_BYTE : NACK_BYTE;
			end else if (st.pend && !fifo_in_ready) begin
				next_st.overrun = 1'b1;
			end else begin
				// Block payload for either entry path goes the same way.
				next_st.pend      = 1'b1;
				next_st.pend_data = b;
			end
		end

		// Transmitter: hardware answers go before software bytes.
		if (!st.tx_busy) begin
			if (st.ack_req || st.txq) begin
				d = st.ack_req ? st.ack_byte : st.txq_data;
				next_st.tx_sh   = {1'b1, ^d, d, 1'b0};
				next_st.tx_busy = 1'b1;
				next_st.tx_left = FRAME_BITS;
				next_st.tx_cnt  = st.baud_div;
				if (st.ack_req) begin
					next_st.ack_req = 1'b0;
				end else begin
					next_st.txq = 1'b0;
				end
			end
		end else begin
			next_st.tx_cnt = st.tx_cnt - 16'h0001;
			if (st.tx_cnt == 16'h0000) begin
				next_st.tx_cnt  = st.baud_div;
				next_st.tx_sh   = {1'b1, st.tx_sh[10:1]};
				next_st.tx_left = st.tx_left - 4'h1;
				next_st.tx_busy = (st.tx_left != 4'h1);
			end
		end
		next_st.tx_line = next_st.tx_busy ? next_st.tx_sh[0] : 1'b1;

		// Forced reset: options written earlier take effect only now.
		if (st.wdg_rst) begin
			next_st.opt_boot   = (st.opt == OPT_BOOT) && (st.nopt == NOPT_BOOT);
			next_st.unlocked   = 1'b0;
			next_st.unlock_arm = 1'b0;
			next_st.wdg_arm    = 1'b0;
			next_st.cr2        = FCR2_RST;
			next_st.flash_control_two_complement       = NFCR2_RST;
			next_st.synced     = 1'b0;
			next_st.sync_fail  = 1'b0;
			next_st.cmd_wait   = 1'b0;
			next_st.hst        = H_IDLE;
		end
		// Blank flash or the boot option pair selects boot mode.
		next_st.boot_mode = !next_st.programmed || next_st.opt_boot;

		next_st.axi.awready = !next_st.aw_have && !next_st.axi.bvalid;
		next_st.axi.wready  = !next_st.w_have && !next_st.axi.bvalid;
		next_st.axi.arready = !next_st.axi.rvalid;
	end

	// Register the state; reset gives the blank, idle device.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st           <= '0;
			st.baud_div  <= BAUD_DIV_RST;
			st.cr2       <= FCR2_RST;
			st.flash_control_two_complement      <= NFCR2_RST;
			st.opt       <= OPT_RST;
			st.nopt      <= NOPT_RST;
			st.boot_mode <= 1'b1;
			st.irq_sync  <= '0;
			st.rx_sync   <= 2'b11;
			st.tx_line   <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

endmodule

// ### ube_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
module ube_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	import ube_pkg::*;

	localparam int PW = $clog2(D);

	// ----------------------------------------------------------------
	// State: storage, pointers and fill level.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;   // Entries.
		logic [PW-1:0]       wr;    // Next slot to fill.
		logic [PW-1:0]       rd;    // Oldest slot.
		logic [PW:0]         level; // Entries held.
	} ube_fifo_st_t;

	ube_fifo_st_t st;
	ube_fifo_st_t next_st;
	logic         push;
	logic         pop;

	// Full and empty follow the level, so neither side ever overruns.
	assign in_ready  = (st.level != (PW+1)'(D));
	assign out_valid = (st.level != '0);
	assign out_data  = st.mem[st.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer and level update; a push and a pop together keep the level.
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr         = st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = st.rd + 1'b1;
		end
		next_st.level = st.level + (PW+1)'(push) - (PW+1)'(pop);
	end

	// Register the state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule

// ### ube_monitor.sv
// Port checker for the boot entry block.
module ube_monitor (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire ube_pkg::ube_axil_req_t  axil_req,
	input wire ube_pkg::ube_axil_resp_t axil_resp,
	input wire logic                    uart_rx_in,
	input wire logic                    uart_tx_out,
	input wire logic                    boot_force_irq_in,
	input wire logic                    watchdog_forced_reset,
	input wire logic                    boot_mode_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import ube_pkg::*;
	// All checks share the one clock and its reset.
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_wdg_single: assert property (
		watchdog_forced_reset |=> !watchdog_forced_reset)
		else $error("watchdog reset pulse too wide");
	a_boot_entry: assert property (
		watchdog_forced_reset |=> boot_mode_out)
		else $error("no boot mode after forced reset");
	a_tx_idle: assert property ($rose(aresetn) |-> uart_tx_out)
		else $error("transmit line not idle high");
	a_b_once: assert property (
		axil_resp.bvalid && axil_req.bready |=> !axil_resp.bvalid)
		else $error("write answer repeated");
	a_r_once: assert property (
		axil_resp.rvalid && axil_req.rready |=> !axil_resp.rvalid)
		else $error("read answer repeated");
	a_r_latency: assert property (
		axil_req.arvalid && axil_resp.arready |=> axil_resp.rvalid)
		else $error("read answer late");
	a_ar_blocked: assert property (axil_resp.rvalid |-> !axil_resp.arready)
		else $error("read address taken while answering");
	a_w_answer: assert property (axil_req.awvalid && axil_resp.awready
		&& axil_req.wvalid && axil_resp.wready |-> ##[1:10] axil_resp.bvalid)
		else $error("write answer missing");
	a_w_blocked: assert property (axil_resp.bvalid
		|-> !axil_resp.awready && !axil_resp.wready)
		else $error("write taken while answering");
	c_force: cover property (watchdog_forced_reset);
	c_slverr: cover property (axil_resp.rvalid && axil_resp.rresp[1]);
	c_tx_frame: cover property ($fell(uart_tx_out));
endmodule
bind ube_boot_entry ube_monitor u_ube_monitor (.aclk(aclk),
	.aresetn(aresetn), .axil_req(axil_req), .axil_resp(axil_resp),
	.uart_rx_in(uart_rx_in), .uart_tx_out(uart_tx_out),
	.boot_force_irq_in(boot_force_irq_in),
	.watchdog_forced_reset(watchdog_forced_reset),
	.boot_mode_out(boot_mode_out));

// ### ube_pkg.sv
// Constants, types and bus carriers shared by the boot entry design.
package ube_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses on the AXI4-Lite bus.
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 18;
	localparam logic [17:0] CTRL_ADDR     = 18'h00000; // Handler enable, image.
	localparam logic [17:0] BAUD_ADDR     = 18'h00004; // Bit period in cycles, minus one.
	localparam logic [17:0] STATUS_ADDR   = 18'h00008; // State, W1C flags.
	localparam logic [17:0] RXDATA_ADDR   = 18'h0000C; // Pops the FIFO.
	localparam logic [17:0] TXDATA_ADDR   = 18'h00010; // Queues one byte.
	localparam logic [17:0] CMD_ADDR      = 18'h00014; // Last command.
	localparam logic [17:0] UNLOCK_ADDR   = 18'h00018; // data_unlock_key_reg.
	localparam logic [17:0] FCR2_ADDR     = 18'h0001C; // flash_control_two.
	localparam logic [17:0] NFCR2_ADDR    = 18'h00020; // Its complement.
	localparam logic [17:0] WDG_KEY_ADDR  = 18'h00024; // watchdog_key_reg.
	// The option bytes are given by word index, so their byte address is 4x.
	localparam logic [15:0] OPT_INDEX     = 16'h487E;
	localparam logic [15:0] NOPT_INDEX    = 16'h487F;
	localparam logic [17:0] OPT_ADDR      = {OPT_INDEX, 2'b00};
	localparam logic [17:0] NOPT_ADDR     = {NOPT_INDEX, 2'b00};

	// ----------------------------------------------------------------
	// Reset values, keys and option values.
	// ----------------------------------------------------------------
	localparam logic [7:0]  FCR2_RST      = 8'h00;
	localparam logic [7:0]  NFCR2_RST     = 8'hFF;
	localparam logic [7:0]  OPT_RST       = 8'h00;
	localparam logic [7:0]  NOPT_RST      = 8'h00;
	localparam logic [7:0]  UNLOCK_KEY1   = 8'hAE;
	localparam logic [7:0]  UNLOCK_KEY2   = 8'h56;
	localparam logic [7:0]  OPT_WR_SET    = 8'h80;
	localparam logic [7:0]  OPT_WR_CLR    = 8'h7F;
	localparam logic [7:0]  OPT_BOOT      = 8'h55;
	localparam logic [7:0]  NOPT_BOOT     = 8'hAA;
	localparam logic [7:0]  WDG_KEY1      = 8'hCC;
	localparam logic [7:0]  WDG_KEY2      = 8'h55;

	// ----------------------------------------------------------------
	// Link protocol bytes and timing.
	// ----------------------------------------------------------------
	localparam logic [7:0]  SYNC_BYTE     = 8'h7F;
	localparam logic [7:0]  ACK_BYTE      = 8'h79;
	localparam logic [7:0]  NACK_BYTE     = 8'h1F;
	localparam logic [7:0]  CMD_GET       = 8'h00;
	localparam logic [7:0]  CMD_READ      = 8'h11;
	localparam logic [7:0]  CMD_GO        = 8'h21;
	localparam logic [7:0]  CMD_WRITE     = 8'h31;
	localparam logic [7:0]  CMD_ERASE     = 8'h43;
	localparam logic [3:0]  FRAME_BITS    = 4'hB;
	localparam int          CLK_HZ        = 100_000_000;
	localparam int          BAUD_RST      = 115_200;
	localparam logic [15:0] BAUD_DIV_RST  = 16'(CLK_HZ / BAUD_RST);
	localparam int          FIFO_W        = 8;
	localparam int          FIFO_D        = 16;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;

	// ----------------------------------------------------------------
	// Types.
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		H_IDLE     = 4'h0,
		H_UNLOCK_A = 4'h1,
		H_UNLOCK_B = 4'h2,
		H_CR2      = 4'h3,
		H_FLASH_CONTROL_TWO_COMPLEMENT     = 4'h4,
		H_OPT      = 4'h5,
		H_NOPT     = 4'h6,
		H_KEY_A    = 4'h7,
		H_KEY_B    = 4'h8
	} ube_hstate_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'h0,
		RX_START = 3'h1,
		RX_DATA  = 3'h2,
		RX_PAR   = 3'h3,
		RX_STOP  = 3'h4
	} ube_rxstate_t;

	typedef struct packed {
		logic        awvalid;
		logic [17:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [17:0] araddr;
		logic        rready;
	} ube_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ube_axil_resp_t;

endpackage

// ### ube_prog_model.sv
// Behavioural programmer: UART host and boot-force pulser.
module ube_prog_model #(
	parameter int BIT = 10 // Cycles per UART bit.
) (
	input  wire logic  aclk,
	input  wire logic  line_in,   // Target transmit.
	output logic       line_out,  // Target receive, idles high.
	output logic       force_out, // Boot-force pin.
	output logic       got,       // One cycle per good frame heard.
	output logic [7:0] got_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] tsh;
	logic [9:0]  rsh;
	initial begin
		line_out = 1'b1;
		force_out = 1'b0;
		got = 1'b0;
		got_byte = 8'h00;
	end
	// Start, data LSB first, even parity, stop; bad flips the parity.
	task automatic send(input logic [7:0] b, input logic bad);
		tsh = {1'b1, ^b ^ bad, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line_out <= tsh[i];
			repeat (BIT) @(posedge aclk);
		end
	endtask
	// Held several cycles so the target's edge catch cannot miss it.
	task automatic pulse(input int n);
		force_out <= 1'b1;
		repeat (n) @(posedge aclk);
		force_out <= 1'b0;
	endtask
	// Samples mid-cell; a bad parity or stop bit drops the frame.
	always begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge aclk);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT) @(posedge aclk);
			rsh[i] = line_in;
		end
		got_byte <= rsh[7:0];
		got <= rsh[9] && !(^rsh[8:0]);
		@(posedge aclk);
		got <= 1'b0;
	end
endmodule
